// [pkg/tal_pkg.sv]
// tal_pkg: constants of the tdm audio expansion link
// assumes: one system clock of 40 MHz, bit clock arrives on a pin
package tal_pkg;
  // --------------------------------------------------------------
  // frame layout
  // --------------------------------------------------------------
  localparam int          FRAME_BITS      = 256;
  localparam int          SUBFRAME_BITS   = 64;
  localparam int          SLOT_BITS       = 32;
  localparam int          DATA_BITS       = 20;
  localparam int          AUX_BITS        = 12;
  localparam int          BIT_CNT_W       = 8;
  localparam int          SLOT_IDX_W      = 3;
  localparam int          DATA_MSB        = 31;
  localparam int          DATA_LSB        = 12;
  localparam int          AUX_MSB         = 11;
  localparam logic [4:0]  SLOT_LAST       = 5'h1F;
  localparam logic [4:0]  SLOT_FIRST      = 5'h00;
  localparam logic [1:0]  SYS_SUBFRAME    = 2'h0;
  localparam logic [7:0]  FRAME_SYNC_BITS = 8'h02;
  localparam int          BCLK_PER_SAMPLE = 256;
  // --------------------------------------------------------------
  // clocks and reset values
  // --------------------------------------------------------------
  localparam int          SYS_CLK_HZ      = 40000000;
  localparam int          MASTER_CLK_HZ   = 24576000;
  localparam logic [7:0]  BIT_CNT_RST     = 8'h00;
  localparam logic [2:0]  SLOT_IDX_RST    = 3'h0;
  localparam logic [31:0] WORD_RST        = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } tal_state_t;
endpackage

// [pkg/tal_if.sv]
// tal_if: carriers between the link modules
// assumes: tal_pkg compiled first
interface tal_edge_if;
  logic bclk_rise;
  logic bclk_fall;
  logic sdin;
  modport src (output bclk_rise, output bclk_fall, output sdin);
  modport dst (input bclk_rise, input bclk_fall, input sdin);
endinterface

interface tal_slot_if;
  logic        load;
  logic [31:0] load_word;
  logic        shift;
  logic        sample;
  logic        sample_bit;
  logic        next_bit;
  logic [31:0] rx_word;
  modport ctl (output load, output load_word, output shift, output sample,
               output sample_bit, input next_bit, input rx_word);
  modport dp  (input load, input load_word, input shift, input sample,
               input sample_bit, output next_bit, output rx_word);
endinterface

// [src/tal_link_sync.sv]
// tal_link_sync: synchronises bit clock and inbound data, finds edges
// assumes: pins are asynchronous to i_clk, bit clock far slower
module tal_link_sync
  import tal_pkg::*;
(
  input  wire logic   i_clk,
  input  wire logic   i_rst,
  input  wire logic   i_bclk_pin,
  input  wire logic   i_sdin_pin,
  tal_edge_if.src     edge_o
);
  logic [2:0] bclk_q;
  logic [2:0] bclk_d;
  logic [1:0] sdin_q;
  logic [1:0] sdin_d;

  always_comb begin
    bclk_d = {bclk_q[1:0], i_bclk_pin};
    sdin_d = {sdin_q[0], i_sdin_pin};
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bclk_q <= 3'h0;
      sdin_q <= 2'h0;
    end else begin
      bclk_q <= bclk_d;
      sdin_q <= sdin_d;
    end
  end

  // edges seen only on the bit clock [RQ3]
  assign edge_o.bclk_rise = bclk_q[1] & ~bclk_q[2];
  assign edge_o.bclk_fall = ~bclk_q[1] & bclk_q[2];
  assign edge_o.sdin      = sdin_q[1];

  AST_EDGE_EXCL: assert property (@(posedge i_clk) disable iff (i_rst)
    !(edge_o.bclk_rise && edge_o.bclk_fall)) // [RQ3]
    else $error("rise and fall in one cycle");
endmodule

// [src/tal_slot_shift.sv]
// tal_slot_shift: 32-bit slot serialiser and deserialiser, msb first
// assumes: load, shift and sample come from the link controller
module tal_slot_shift
  import tal_pkg::*;
(
  input  wire logic   i_clk,
  input  wire logic   i_rst,
  tal_slot_if.dp      slot
);
  logic [31:0] tx_q;
  logic [31:0] tx_d;
  logic [31:0] rx_q;
  logic [31:0] rx_d;

  always_comb begin
    tx_d = tx_q;
    rx_d = rx_q;
    if (slot.load) begin
      tx_d = slot.load_word;
    end else if (slot.shift) begin
      tx_d = {tx_q[30:0], 1'b0}; // [RQ13]
    end
    if (slot.sample) begin
      rx_d = {rx_q[30:0], slot.sample_bit}; // [RQ13]
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tx_q <= WORD_RST;
      rx_q <= WORD_RST;
    end else begin
      tx_q <= tx_d;
      rx_q <= rx_d;
    end
  end

  // msb leaves first [RQ13]
  assign slot.next_bit = slot.load ? slot.load_word[31] : tx_q[30];
  assign slot.rx_word  = {rx_q[30:0], slot.sample_bit};
endmodule

// [src/tal_link.sv]
// tal_link: device end of the tdm audio expansion link
// assumes: bit clock from the clock generator on a pin, sample ports
// assumes: on the system clock, master clock gated outside
//
// Function
// RQ1: the device offers a 24.576 MHz master clock to the card.
// RQ2: the bit clock runs at 256 times the sample rate, one frame per sample.
// RQ3: sync and both data lines are timed by the bit clock alone.
// RQ4: a frame is 256 bits made of four 64-bit subframes.
// RQ5: each subframe holds a left and a right 32-bit slot.
// RQ6: each slot carries 20 audio bits and 12 auxiliary bits.
// RQ7: subframe 1 belongs to the system's own sound, the rest to cards.
// RQ8: drivers change lines on the falling edge, receivers sample on rising.
// RQ9: a frame start is a sync pulse two bit clocks wide.
// RQ10: a word start is a sync pulse one bit clock wide.
// RQ11: the device drives sync to mark every frame and word start.
// RQ12: outbound data goes to the card, inbound data comes from it.
// RQ13: slots go msb first, audio bits ahead of auxiliary bits.
// RQ14: the left slot of a subframe goes before the right slot.
module tal_link
  import tal_pkg::*;
(
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_SYS_RST,
  input  wire logic        I_SERIAL_BIT_CLOCK,
  input  wire logic        I_SERIAL_IN_FROM_CARD,
  input  wire logic [19:0] I_CODEC_TX_SAMPLE,
  input  wire logic [11:0] I_CODEC_TX_AUX,
  input  wire logic [19:0] I_DMA_TX_SAMPLE,
  input  wire logic [11:0] I_DMA_TX_AUX,
  output logic             O_SERIAL_OUT_TO_CARD,
  output logic             O_FRAME_WORD_SYNC,
  output logic             O_AUDIO_MASTER_CLK_EN,
  output logic             O_LINK_ACTIVE,
  output logic             O_TX_TAKEN,
  output logic [2:0]       O_TX_NEXT_SLOT,
  output logic             O_RX_VALID,
  output logic [2:0]       O_RX_SLOT,
  output logic [19:0]      O_RX_SAMPLE,
  output logic [11:0]      O_RX_AUX
);
  // --------------------------------------------------------------
  // pin sampling and slot datapath
  // --------------------------------------------------------------
  tal_edge_if lnk ();
  tal_slot_if slot ();

  tal_link_sync u_sync (
    .i_clk      (I_SYS_CLK),
    .i_rst      (I_SYS_RST),
    .i_bclk_pin (I_SERIAL_BIT_CLOCK),
    .i_sdin_pin (I_SERIAL_IN_FROM_CARD),
    .edge_o     (lnk.src)
  );

  tal_slot_shift u_shift (
    .i_clk (I_SYS_CLK),
    .i_rst (I_SYS_RST),
    .slot  (slot.dp)
  );

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  tal_state_t  state_q;
  tal_state_t  state_d;
  logic [7:0]  bit_cnt_q;
  logic [7:0]  bit_cnt_d;
  logic [7:0]  new_idx;
  logic        out_q;
  logic        out_d;
  logic        sync_q;
  logic        sync_d;
  logic        taken_q;
  logic        taken_d;
  logic [2:0]  next_slot_q;
  logic [2:0]  next_slot_d;
  logic        rxv_q;
  logic        rxv_d;
  logic [2:0]  rx_slot_q;
  logic [2:0]  rx_slot_d;
  logic [19:0] rx_sample_q;
  logic [19:0] rx_sample_d;
  logic [11:0] rx_aux_q;
  logic [11:0] rx_aux_d;
  logic        mclk_en_q;
  logic        mclk_en_d;

  // --------------------------------------------------------------
  // next values
  // --------------------------------------------------------------
  always_comb begin
    state_d     = state_q;
    bit_cnt_d   = bit_cnt_q;
    out_d       = out_q;
    sync_d      = sync_q;
    taken_d     = 1'b0;
    next_slot_d = next_slot_q;
    rxv_d       = 1'b0;
    rx_slot_d   = rx_slot_q;
    rx_sample_d = rx_sample_q;
    rx_aux_d    = rx_aux_q;
    mclk_en_d   = 1'b1; // [RQ1]
    // 256-bit frame counter wraps on its own width [RQ2] [RQ4]
    new_idx     = (state_q == ST_RUN) ? 8'(bit_cnt_q + 8'h01) : BIT_CNT_RST;
    // subframe 1 is filled from the system codec [RQ7]
    if (new_idx[7:6] == SYS_SUBFRAME) begin
      slot.load_word = {I_CODEC_TX_SAMPLE, I_CODEC_TX_AUX}; // [RQ6] [RQ13]
    end else begin
      slot.load_word = {I_DMA_TX_SAMPLE, I_DMA_TX_AUX}; // [RQ12]
    end
    slot.load       = lnk.bclk_fall && (new_idx[4:0] == SLOT_FIRST); // [RQ5]
    slot.shift      = lnk.bclk_fall && !slot.load;
    slot.sample     = lnk.bclk_rise && (state_q == ST_RUN); // [RQ8]
    slot.sample_bit = lnk.sdin;
    // lines change only after a falling edge [RQ8]
    if (lnk.bclk_fall) begin
      state_d   = ST_RUN;
      bit_cnt_d = new_idx;
      out_d     = slot.next_bit; // [RQ12]
      // frame sync two wide, word sync one wide [RQ9] [RQ10] [RQ11]
      sync_d    = (new_idx < FRAME_SYNC_BITS) || (new_idx[4:0] == SLOT_FIRST);
    end
    if (slot.load) begin
      taken_d     = 1'b1;
      // left then right, subframe by subframe [RQ14]
      next_slot_d = 3'(new_idx[7:5] + 3'h1);
    end
    // last bit of a slot arrives on a rising edge [RQ8]
    if (slot.sample && (bit_cnt_q[4:0] == SLOT_LAST)) begin
      // inbound subframe 1 is not taken from the card [RQ7]
      if (bit_cnt_q[7:6] != SYS_SUBFRAME) begin
        rxv_d       = 1'b1;
        rx_slot_d   = bit_cnt_q[7:5];
        rx_sample_d = slot.rx_word[DATA_MSB:DATA_LSB]; // [RQ6]
        rx_aux_d    = slot.rx_word[AUX_MSB:0];
      end
    end
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      state_q     <= ST_IDLE;
      bit_cnt_q   <= BIT_CNT_RST;
      out_q       <= 1'b0;
      sync_q      <= 1'b0;
      taken_q     <= 1'b0;
      next_slot_q <= SLOT_IDX_RST;
      rxv_q       <= 1'b0;
      rx_slot_q   <= SLOT_IDX_RST;
      rx_sample_q <= 20'h00000;
      rx_aux_q    <= 12'h000;
      mclk_en_q   <= 1'b0;
    end else begin
      state_q     <= state_d;
      bit_cnt_q   <= bit_cnt_d;
      out_q       <= out_d;
      sync_q      <= sync_d;
      taken_q     <= taken_d;
      next_slot_q <= next_slot_d;
      rxv_q       <= rxv_d;
      rx_slot_q   <= rx_slot_d;
      rx_sample_q <= rx_sample_d;
      rx_aux_q    <= rx_aux_d;
      mclk_en_q   <= mclk_en_d;
    end
  end

  assign O_SERIAL_OUT_TO_CARD  = out_q;
  assign O_FRAME_WORD_SYNC     = sync_q;
  assign O_AUDIO_MASTER_CLK_EN = mclk_en_q;
  assign O_LINK_ACTIVE         = (state_q == ST_RUN);
  assign O_TX_TAKEN            = taken_q;
  assign O_TX_NEXT_SLOT        = next_slot_q;
  assign O_RX_VALID            = rxv_q;
  assign O_RX_SLOT             = rx_slot_q;
  assign O_RX_SAMPLE           = rx_sample_q;
  assign O_RX_AUX              = rx_aux_q;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_SYS_RST);

  sequence s_frame_start;
    lnk.bclk_fall && (bit_cnt_q == 8'hFF) && (state_q == ST_RUN);
  endsequence

  // first bit of a frame carries sync, AST_FRAME_SYNC_TWO allows sync outside word starts on the second bit only
  sequence s_frame_sync_held;
    sync_q && (bit_cnt_q == 8'h00);
  endsequence

  AST_FRAME_WRAP: assert property (s_frame_start |=> bit_cnt_q == 8'h00) // [RQ4]
    else $error("frame not 256 bits");

  AST_FRAME_SYNC_TWO: assert property (
    (state_q == ST_RUN) && sync_q && (bit_cnt_q[4:0] != SLOT_FIRST)
    |-> bit_cnt_q == 8'h01) // [RQ9]
    else $error("sync high beyond frame start");

  AST_FRAME_SYNC_START: assert property (s_frame_start |=> s_frame_sync_held) // [RQ9]
    else $error("frame sync not two bit clocks");

  AST_WORD_SYNC: assert property (
    (state_q == ST_RUN) && (bit_cnt_q[4:0] == SLOT_FIRST) |-> sync_q) // [RQ10]
    else $error("word start without sync");

  AST_SYNC_ON_FALL: assert property (
    $changed(O_FRAME_WORD_SYNC) |-> $past(lnk.bclk_fall)) // [RQ11]
    else $error("sync changed off falling edge");

  AST_OUT_ON_FALL: assert property (
    $changed(O_SERIAL_OUT_TO_CARD) |-> $past(lnk.bclk_fall)) // [RQ8]
    else $error("data changed off falling edge");

  AST_MSB_FIRST: assert property (
    O_TX_TAKEN |-> O_SERIAL_OUT_TO_CARD == $past(slot.load_word[31])) // [RQ13]
    else $error("slot not sent msb first");

  AST_CODEC_SLOT: assert property (
    O_TX_TAKEN && (bit_cnt_q[7:6] == SYS_SUBFRAME)
    |-> O_SERIAL_OUT_TO_CARD == $past(I_CODEC_TX_SAMPLE[19])) // [RQ7]
    else $error("subframe 1 not from codec");

  AST_LEFT_RIGHT: assert property (
    O_TX_TAKEN |-> O_TX_NEXT_SLOT == 3'(bit_cnt_q[7:5] + 3'h1)) // [RQ14]
    else $error("slot order broken");

  AST_RX_NOT_SYS: assert property (
    O_RX_VALID |-> O_RX_SLOT[2:1] != SYS_SUBFRAME) // [RQ7]
    else $error("card data taken in subframe 1");

  AST_RX_ON_RISE: assert property (
    O_RX_VALID |-> $past(lnk.bclk_rise) && $past(bit_cnt_q[4:0]) == SLOT_LAST) // [RQ8]
    else $error("slot captured off rising edge");

  AST_MCLK_ON: assert property ($fell(I_SYS_RST) |-> ##1 O_AUDIO_MASTER_CLK_EN [*2]) // [RQ1]
    else $error("master clock not enabled");
endmodule

// [dv/tal_card_model.sv]
// tal_card_model: card end of the link, makes the bit clock
// assumes: sync and outbound data change after the bit clock falls
module tal_card_model
(
  input  wire logic i_rst,
  input  wire logic i_run,
  input  wire logic i_sync,
  input  wire logic i_sdo,
  output logic      o_bclk,
  output logic      o_sdi
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  cnt;
  logic        lock;
  logic        psync;
  logic [31:0] sh;
  logic [31:0] got [8];
  int          sync_err;
  int          frames;
  initial begin
    o_bclk = 1'b1;
    o_sdi = 1'b0;
    {lock, psync, cnt, sh, sync_err, frames} = '0;
  end
  // bit clock, 200 ns period, runs only while enabled
  always begin
    wait (i_run);
    #100 o_bclk = 1'b0;
    #100 o_bclk = 1'b1;
  end
  always @(posedge i_rst) lock = 1'b0;
  // sample on the rise, check sync position against own bit count
  always @(posedge o_bclk) begin
    if (i_sync && psync) begin
      if (lock && cnt != 8'h00) sync_err++;
      lock = 1'b1;
      cnt = 8'h01;
      frames++;
    end else begin
      cnt = cnt + 8'h01;
      if (lock && i_sync !== (cnt == 8'h01 || cnt[4:0] == 5'h00)) sync_err++;
    end
    sh = {sh[30:0], i_sdo};
    if (lock && cnt[4:0] == 5'h1F) got[cnt[7:5]] = sh;
    psync = i_sync;
  end
  // inbound word per slot, driven on the fall, msb first
  always @(negedge o_bclk) begin : drive
    logic [7:0]  nx;
    logic [31:0] w;
    nx = cnt + 8'h01;
    w = 32'h9F42_E100 | 32'(nx[7:5]);
    o_sdi <= lock ? w[5'h1F - nx[4:0]] : ~o_sdi;
  end
endmodule

// [dv/tb_top.sv]
// tb_top: self-checking bench of tal_link with a card model
// assumes: 40 MHz system clock, bit clock made by the card model
module tb_top;
  import tal_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] cw, dw, xo, xr; logic rq;} tal_row_t;
  logic        I_SYS_CLK, I_SYS_RST, bclk, sdin, run;
  logic [19:0] I_CODEC_TX_SAMPLE, I_DMA_TX_SAMPLE;
  logic [11:0] I_CODEC_TX_AUX, I_DMA_TX_AUX;
  logic        sdo, sync, mclk_en, active, taken, rx_valid;
  logic [2:0]  next_slot, rx_slot;
  logic [19:0] rx_sample;
  logic [11:0] rx_aux;
  tal_row_t    rows [8];
  logic [31:0] rx_seen [8];
  int          rx_n [8];
  int          fails, n_compared, cyc;
  logic [2:0]  nx_exp;
  tal_link uut (.I_SYS_CLK(I_SYS_CLK), .I_SYS_RST(I_SYS_RST), .I_SERIAL_BIT_CLOCK(bclk),
    .I_SERIAL_IN_FROM_CARD(sdin), .I_CODEC_TX_SAMPLE(I_CODEC_TX_SAMPLE),
    .I_CODEC_TX_AUX(I_CODEC_TX_AUX), .I_DMA_TX_SAMPLE(I_DMA_TX_SAMPLE),
    .I_DMA_TX_AUX(I_DMA_TX_AUX), .O_SERIAL_OUT_TO_CARD(sdo), .O_FRAME_WORD_SYNC(sync),
    .O_AUDIO_MASTER_CLK_EN(mclk_en), .O_LINK_ACTIVE(active), .O_TX_TAKEN(taken),
    .O_TX_NEXT_SLOT(next_slot), .O_RX_VALID(rx_valid), .O_RX_SLOT(rx_slot),
    .O_RX_SAMPLE(rx_sample), .O_RX_AUX(rx_aux));
  tal_card_model card (.i_rst(I_SYS_RST), .i_run(run), .i_sync(sync), .i_sdo(sdo),
    .o_bclk(bclk), .o_sdi(sdin));
  always #12.5 I_SYS_CLK = ~I_SYS_CLK;
  // ----------------------------------------------------------------
  // stimulus and monitors
  // ----------------------------------------------------------------
  always @(posedge I_SYS_CLK) begin
    #1;
    {I_CODEC_TX_SAMPLE, I_CODEC_TX_AUX} = rows[next_slot].cw;
    {I_DMA_TX_SAMPLE, I_DMA_TX_AUX} = rows[next_slot].dw;
  end
  always @(posedge I_SYS_CLK) begin
    if (rx_valid === 1'b1) begin
      rx_seen[rx_slot] = {rx_sample, rx_aux};
      rx_n[rx_slot]++;
    end
    if (I_SYS_RST === 1'b1) begin
      nx_exp = 3'h1;
    end else if (taken === 1'b1) begin
      chk("next slot", 32'(nx_exp), 32'(next_slot));
      nx_exp = 3'(nx_exp + 3'h1);
    end
    cyc++;
    if (cyc == 20000) begin
      fails++;
      $display("[FAIL] timeout");
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check_rows;
    for (int k = 0; k < 8; k++) begin
      chk($sformatf("card word %0d", k), rows[k].xo, card.got[k]);
      chk($sformatf("rx seen %0d", k), 32'(rows[k].rq), 32'(rx_n[k] != 0));
      if (rows[k].rq) chk($sformatf("rx word %0d", k), rows[k].xr, rx_seen[k]);
      card.got[k] = '0;
      rx_seen[k] = '0;
      rx_n[k] = 0;
    end
    chk("sync errors", 32'h0, 32'(card.sync_err));
    chk("link active", 32'h1, 32'(active));
  endtask
  task automatic reset_checks;
    chk("sync in reset", 32'h0, 32'(sync));
    chk("out in reset", 32'h0, 32'(sdo));
    chk("taken in reset", 32'h0, 32'(taken));
    chk("active in reset", 32'h0, 32'(active));
    chk("next in reset", 32'h0, 32'(next_slot));
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {I_SYS_CLK, run, fails, n_compared, cyc} = '0;
    I_SYS_RST = 1'b1;
    {I_CODEC_TX_SAMPLE, I_CODEC_TX_AUX, I_DMA_TX_SAMPLE, I_DMA_TX_AUX} = '0;
    for (int k = 0; k < 8; k++) begin
      rows[k].cw = 32'hC0DE_A500 | k;
      rows[k].dw = 32'h3B61_7200 | k;
      rows[k].xo = (k < 2) ? rows[k].cw : rows[k].dw;
      rows[k].xr = 32'h9F42_E100 | k;
      rows[k].rq = (k >= 2);
      rx_n[k] = 0;
    end
    repeat (2) @(posedge I_SYS_CLK);
    #1 reset_checks();
    I_SYS_RST = 1'b0;
    @(posedge I_SYS_CLK);
    #1 chk("master clock enable", 32'h1, 32'(mclk_en));
    chk("active before bit clock", 32'h0, 32'(active));
    #12 run = 1'b1;
    repeat (6400) @(posedge I_SYS_CLK);
    chk("frames seen", 32'h1, 32'(card.frames >= 2));
    check_rows();
    repeat (1000) @(posedge I_SYS_CLK);
    #1 I_SYS_RST = 1'b1;
    run = 1'b0;
    repeat (12) @(posedge I_SYS_CLK);
    #1 reset_checks();
    I_SYS_RST = 1'b0;
    #12 run = 1'b1;
    repeat (4400) @(posedge I_SYS_CLK);
    check_rows();
    complete_run();
  end
endmodule
